// ### rtl/loop_mode_pkg.sv
// Shared constants and carrier types for the analog loop mode control block.
package loop_mode_pkg;
    localparam int CLK_MHZ          = 25;
    localparam int STAGE_NS         = 1000;
    localparam int STAGE_CYC        = (STAGE_NS * CLK_MHZ + 999) / 1000;
    localparam int CAL_TIMEOUT_US   = 1000;
    localparam int CAL_TIMEOUT_CYC  = CAL_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W            = 16;
    localparam int FB_INT_W         = 8;
    localparam int FB_FRAC_W        = 27;
    localparam int RATIO_W          = FB_INT_W + FB_FRAC_W;
    localparam int OFFSET_W         = 32;
    localparam int TRIM_W           = 16;
    localparam int OFFSET_LSB_EXP   = 40;
    localparam int CAP_W            = 6;
    localparam int LPF_W            = 4;
    localparam int LOCK_RANGE_W     = 2;
    localparam int STARTUP_W        = 2;
    localparam int DIV_W            = FB_INT_W + 1;
    localparam logic [FB_FRAC_W-1:0] FRAC_ZERO = 27'h0000000;

    typedef enum logic [2:0] {
        RS_HOLD = 3'b000,
        RS_BIAS = 3'b001,
        RS_CAL  = 3'b010,
        RS_APLL = 3'b011,
        RS_DPLL = 3'b100,
        RS_RUN  = 3'b101
    } rst_state_t;

    typedef struct packed {
        logic [CAP_W-1:0] cap_xin;
        logic [CAP_W-1:0] cap_xout;
    } xtal_cfg_t;

    typedef struct packed {
        logic cmos_sel;
        logic diff_ac_bias_on;
        logic selfbias_cmos_on;
        logic inbuff_en;
    } ref_cfg_t;

    typedef struct packed {
        logic [LPF_W-1:0] filter_r1_value;
        logic [LPF_W-1:0] filter_cp_value;
        logic [LPF_W-1:0] filter_r3_value;
        logic [LPF_W-1:0] filter_c3_value;
        logic             third_pole_bypass;
    } lpf_cfg_t;

    typedef struct packed {
        logic [FB_INT_W-1:0]  feedback_integer_part;
        logic [FB_FRAC_W-1:0] feedback_fraction_numerator;
    } fbdiv_cfg_t;

    typedef struct packed {
        logic [STARTUP_W-1:0] out_startup;
        logic                 lock_sel;
        logic                 dpll_en;
    } mode_cfg_t;
endpackage

// ### rtl/noise_shaping_modulator.sv
// Second-order cascaded noise-shaping modulator steering the multi-ratio divider.
`timescale 1ns/1ps
module noise_shaping_modulator
    import loop_mode_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          fb_tick,
    input  wire loop_mode_pkg::fbdiv_cfg_t     ratio,
    output logic [loop_mode_pkg::DIV_W-1:0]    div_ratio
);
    logic [FB_FRAC_W-1:0] acc1_ff, acc2_ff, nxt_acc1, nxt_acc2;
    logic                 c2_ff, nxt_c2;
    logic [DIV_W-1:0]     div_ff, nxt_div;
    logic [FB_FRAC_W:0]   sum1, sum2;
    logic signed [DIV_W+1:0] pick;

    // Integer ratio moves between int-1 and int+2; int must stay above one.
    always_comb
    begin
        sum1     = {1'b0, acc1_ff} + {1'b0, ratio.feedback_fraction_numerator};
        sum2     = {1'b0, acc2_ff} + sum1;
        nxt_acc1 = acc1_ff;
        nxt_acc2 = acc2_ff;
        nxt_c2   = c2_ff;
        nxt_div  = div_ff;
        pick     = $signed({3'b000, ratio.feedback_integer_part}) + $signed({10'h000, sum1[FB_FRAC_W]})
                   + $signed({10'h000, sum2[FB_FRAC_W]}) - $signed({10'h000, c2_ff});
        if (fb_tick)
        begin
            nxt_acc1 = sum1[FB_FRAC_W-1:0];
            nxt_acc2 = sum2[FB_FRAC_W-1:0];
            nxt_c2   = sum2[FB_FRAC_W];
            nxt_div  = pick[DIV_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc1_ff <= FRAC_ZERO;
            acc2_ff <= FRAC_ZERO;
            c2_ff   <= 1'b0;
            div_ff  <= 9'h000;
        end
        else
        begin
            acc1_ff <= nxt_acc1;
            acc2_ff <= nxt_acc2;
            c2_ff   <= nxt_c2;
            div_ff  <= nxt_div;
        end
    end

    assign div_ratio = div_ff;
endmodule // noise_shaping_modulator

// ### rtl/analog_loop_mode_control.sv
// Mode, power-up reset sequencing, configuration and lock status of the analog loop.
`timescale 1ns/1ps
// Overview of operation
// - In oscillator mode the offset word is scaled by the divide ratio and applied.
// - One offset LSB equals a fractional frequency step of two to the minus forty.
// - Synthesizer modes ignore reference inputs and bypass the digital loop; it may power down.
// - Jitter-attenuator mode steers the loop from the digital loop; offset word unused.
// - Reset selects synthesizer mode; host sets dpll_en and inbuff_en to enter jitter-attenuator mode.
// - Logic held in reset until regulators settle, then released block by block.
// - Bias calibration sets done, or fail and continues; both bits readable.
// - Crystal input and output pins get separate tuning capacitance fields.
// - Select bit picks differential or single-ended input; AC bias bits follow host.
// - Reference pad off out of reset; host enables it for jitter attenuation.
// - Doubler enable and doubler source select between crystal and reference input.
// - Four loop filter fields; third-pole bypass only while the ratio is integer.
// - Modulator switches the multi-ratio divider among integer ratios for a fraction.
// - Fraction is a 27-bit numerator over two to the twenty-seventh.
// - Current lock status is readable and optionally routed to a general output.
// - Falling lock status sets a sticky lock-loss bit held until host clears.
// - In oscillator mode the host crystal trim offset is applied to correct the crystal's initial error.
module analog_loop_mode_control
    import loop_mode_pkg::*;
#(
    parameter int CAL_TIMEOUT = loop_mode_pkg::CAL_TIMEOUT_CYC
)
(
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic                                   regulators_ok,
    input  wire logic                                   bias_cal_finished,
    input  wire logic                                   bias_cal_error,
    input  wire loop_mode_pkg::mode_cfg_t               mode_cfg,
    input  wire loop_mode_pkg::xtal_cfg_t               xtal_cfg,
    input  wire loop_mode_pkg::ref_cfg_t                ref_cfg,
    input  wire loop_mode_pkg::lpf_cfg_t                lpf_cfg,
    input  wire loop_mode_pkg::fbdiv_cfg_t              fbdiv_cfg,
    input  wire logic                                   doubler_en,
    input  wire logic                                   doubler_src_ref,
    input  wire logic [loop_mode_pkg::LOCK_RANGE_W-1:0] lock_range,
    input  wire logic signed [loop_mode_pkg::OFFSET_W-1:0] osc_offset_word,
    input  wire logic signed [loop_mode_pkg::TRIM_W-1:0]   xtal_trim_word,
    input  wire logic signed [loop_mode_pkg::OFFSET_W-1:0] dpll_steer_word,
    input  wire logic                                   apll_lock_raw,
    input  wire logic                                   lock_loss_clear,
    input  wire logic                                   gpio_lock_sel,
    input  wire logic                                   fb_tick,
    output logic                                        bias_rst_n,
    output logic                                        bias_cal_start,
    output logic                                        apll_rst_n,
    output logic                                        dpll_rst_n,
    output logic                                        out_rst_n,
    output logic                                        bias_cal_done,
    output logic                                        bias_cal_fail,
    output logic                                        ja_mode,
    output logic                                        dpll_power_on,
    output loop_mode_pkg::xtal_cfg_t                    xtal_out,
    output loop_mode_pkg::ref_cfg_t                     ref_out,
    output loop_mode_pkg::lpf_cfg_t                     lpf_out,
    output logic                                        doubler_en_out,
    output logic                                        doubler_src_out,
    output logic [loop_mode_pkg::LOCK_RANGE_W-1:0]      lock_range_out,
    output loop_mode_pkg::fbdiv_cfg_t                   fb_ratio_out,
    output logic [loop_mode_pkg::DIV_W-1:0]             div_ratio,
    output logic                                        apll_lock_sts,
    output logic                                        lock_loss,
    output logic                                        gpio_lock
);
    // Power-up sequencer.
    rst_state_t       state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic             done_ff, nxt_done, fail_ff, nxt_fail;
    logic [3:0]       rel_ff, nxt_rel;
    logic             cal_start_ff, nxt_cal_start;

    always_comb
    begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_done      = done_ff;
        nxt_fail      = fail_ff;
        nxt_rel       = rel_ff;
        nxt_cal_start = 1'b0;
        unique case (state_ff)
            RS_HOLD:
            begin
                nxt_rel = 4'h0;
                if (regulators_ok)
                begin
                    nxt_cnt   = 16'h0000;
                    nxt_state = RS_BIAS;
                end
            end
            RS_BIAS:
            begin
                nxt_rel[0] = 1'b1;
                nxt_cnt    = cnt_ff + 16'h0001;
                if (cnt_ff == CNT_W'(STAGE_CYC - 1))
                begin
                    nxt_cnt       = 16'h0000;
                    nxt_cal_start = 1'b1;
                    nxt_state     = RS_CAL;
                end
            end
            RS_CAL:
            begin
                nxt_cnt = cnt_ff + 16'h0001;
                // A stuck calibration still lets startup go on, reported as a failure.
                if (bias_cal_error || cnt_ff == CNT_W'(CAL_TIMEOUT - 1))
                begin
                    nxt_fail  = 1'b1;
                    nxt_cnt   = 16'h0000;
                    nxt_state = RS_APLL;
                end
                else if (bias_cal_finished)
                begin
                    nxt_done  = 1'b1;
                    nxt_cnt   = 16'h0000;
                    nxt_state = RS_APLL;
                end
            end
            RS_APLL:
            begin
                nxt_rel[1] = 1'b1;
                nxt_cnt    = cnt_ff + 16'h0001;
                if (cnt_ff == CNT_W'(STAGE_CYC - 1))
                begin
                    nxt_cnt   = 16'h0000;
                    nxt_state = RS_DPLL;
                end
            end
            RS_DPLL:
            begin
                nxt_rel[2] = 1'b1;
                nxt_cnt    = cnt_ff + 16'h0001;
                if (cnt_ff == CNT_W'(STAGE_CYC - 1))
                begin
                    nxt_state = RS_RUN;
                end
            end
            RS_RUN:
            begin
                nxt_rel[3] = 1'b1;
            end
            default:
            begin
                nxt_state = RS_HOLD;
            end
        endcase
        if (!regulators_ok)
        begin
            nxt_state = RS_HOLD;
            nxt_rel   = 4'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff     <= RS_HOLD;
            cnt_ff       <= 16'h0000;
            done_ff      <= 1'b0;
            fail_ff      <= 1'b0;
            rel_ff       <= 4'h0;
            cal_start_ff <= 1'b0;
        end
        else
        begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            done_ff      <= nxt_done;
            fail_ff      <= nxt_fail;
            rel_ff       <= nxt_rel;
            cal_start_ff <= nxt_cal_start;
        end
    end

    // Mode decode and configuration, all registered so outputs never glitch.
    logic       ja_ff, nxt_ja, dpwr_ff, nxt_dpwr, dbl_ff, nxt_dbl, src_ff, nxt_src;
    xtal_cfg_t  xtal_ff, nxt_xtal;
    ref_cfg_t   ref_ff, nxt_ref;
    lpf_cfg_t   lpf_ff, nxt_lpf;
    logic [LOCK_RANGE_W-1:0] range_ff, nxt_range;

    always_comb
    begin
        nxt_ja    = mode_cfg.dpll_en & ref_cfg.inbuff_en;
        nxt_dpwr  = mode_cfg.dpll_en & rel_ff[2];
        nxt_xtal  = xtal_cfg;
        nxt_ref   = ref_cfg;
        // The pad only powers up when the digital loop can use it.
        nxt_ref.inbuff_en = ref_cfg.inbuff_en & mode_cfg.dpll_en;
        nxt_dbl   = doubler_en;
        nxt_src   = doubler_src_ref;
        nxt_lpf   = lpf_cfg;
        // Bypassing the third pole with a live fraction would pass modulator noise to the oscillator.
        nxt_lpf.third_pole_bypass = lpf_cfg.third_pole_bypass &
                                    (fbdiv_cfg.feedback_fraction_numerator == FRAC_ZERO);
        nxt_range = lock_range;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ja_ff    <= 1'b0;
            dpwr_ff  <= 1'b0;
            xtal_ff  <= '0;
            ref_ff   <= '0;
            dbl_ff   <= 1'b0;
            src_ff   <= 1'b0;
            lpf_ff   <= '0;
            range_ff <= 2'h0;
        end
        else
        begin
            ja_ff    <= nxt_ja;
            dpwr_ff  <= nxt_dpwr;
            xtal_ff  <= nxt_xtal;
            ref_ff   <= nxt_ref;
            dbl_ff   <= nxt_dbl;
            src_ff   <= nxt_src;
            lpf_ff   <= nxt_lpf;
            range_ff <= nxt_range;
        end
    end

    // Feedback ratio with frequency offset, scaled by the nominal ratio.
    logic signed [OFFSET_W:0]           off_sum;
    logic signed [RATIO_W+OFFSET_W+1:0] prod;
    logic signed [RATIO_W+1:0]          eff;
    fbdiv_cfg_t                         ratio_ff, nxt_ratio;

    always_comb
    begin
        if (ja_ff)
        begin
            off_sum = {dpll_steer_word[OFFSET_W-1], dpll_steer_word};
        end
        else
        begin
            off_sum = (OFFSET_W+1)'(osc_offset_word) + (OFFSET_W+1)'(xtal_trim_word);
        end
        prod      = $signed({1'b0, fbdiv_cfg}) * off_sum;
        eff       = $signed({2'b00, fbdiv_cfg}) + (RATIO_W+2)'(prod >>> OFFSET_LSB_EXP);
        nxt_ratio = eff[RATIO_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ratio_ff <= '0;
        end
        else
        begin
            ratio_ff <= nxt_ratio;
        end
    end

    noise_shaping_modulator u_mod
    (
        .clk       (clk),
        .rst_n     (rst_n & rel_ff[1]),
        .fb_tick   (fb_tick),
        .ratio     (ratio_ff),
        .div_ratio (div_ratio)
    );

    // Lock status and sticky loss event.
    logic lock_ff, nxt_lock, lol_ff, nxt_lol, gpio_ff, nxt_gpio;

    always_comb
    begin
        nxt_lock = apll_lock_raw & rel_ff[1];
        nxt_gpio = gpio_lock_sel & nxt_lock;
        nxt_lol  = lol_ff;
        if (lock_loss_clear)
        begin
            nxt_lol = 1'b0;
        end
        if (lock_ff && !nxt_lock)
        begin
            nxt_lol = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lock_ff <= 1'b0;
            lol_ff  <= 1'b0;
            gpio_ff <= 1'b0;
        end
        else
        begin
            lock_ff <= nxt_lock;
            lol_ff  <= nxt_lol;
            gpio_ff <= nxt_gpio;
        end
    end

    assign bias_rst_n      = rel_ff[0];
    assign bias_cal_start  = cal_start_ff;
    assign apll_rst_n      = rel_ff[1];
    assign dpll_rst_n      = rel_ff[2];
    assign out_rst_n       = rel_ff[3];
    assign bias_cal_done   = done_ff;
    assign bias_cal_fail   = fail_ff;
    assign ja_mode         = ja_ff;
    assign dpll_power_on   = dpwr_ff;
    assign xtal_out        = xtal_ff;
    assign ref_out         = ref_ff;
    assign lpf_out         = lpf_ff;
    assign doubler_en_out  = dbl_ff;
    assign doubler_src_out = src_ff;
    assign lock_range_out  = range_ff;
    assign fb_ratio_out    = ratio_ff;
    assign apll_lock_sts   = lock_ff;
    assign lock_loss       = lol_ff;
    assign gpio_lock       = gpio_ff;
endmodule // analog_loop_mode_control

// ### dv/host_model.sv
// Host-side model that programs the mode, input, filter and lock range bits.
`timescale 1ns/1ps
module host_model
    import loop_mode_pkg::*;
(
    input  wire logic                                   ja_req,
    input  wire logic                                   cmos_req,
    input  wire logic                                   ac_req,
    input  wire logic                                   byp_req,
    input  wire logic                                   byp_force,
    input  wire logic [1:0]                             ref_band,
    input  wire logic [loop_mode_pkg::FB_FRAC_W-1:0]    frac,
    output loop_mode_pkg::mode_cfg_t                    mode_cfg,
    output loop_mode_pkg::ref_cfg_t                     ref_cfg,
    output logic                                        bypass,
    output logic [loop_mode_pkg::LOCK_RANGE_W-1:0]      lock_range
);
    // Mode bits move together so no half mode change is seen.
    always_comb
    begin
        mode_cfg.out_startup = ja_req ? 2'h1 : 2'h2;
        mode_cfg.lock_sel = ja_req;
        mode_cfg.dpll_en = ja_req;
        ref_cfg.inbuff_en = ja_req;
        ref_cfg.cmos_sel = cmos_req;
        ref_cfg.diff_ac_bias_on = ac_req & ~cmos_req;
        ref_cfg.selfbias_cmos_on = ac_req & cmos_req;
        // A forced bypass breaks the host's side on purpose to test the gate.
        bypass = byp_req & (byp_force | (frac == 27'h0000000));
        lock_range = ref_band;
    end
endmodule // host_model

// ### dv/loop_mode_chk_sva.sv
// Port-level assertions for the analog loop mode control block.
`timescale 1ns/1ps
module loop_mode_chk
    import loop_mode_pkg::*;
#(
    parameter int CAL_TIMEOUT = CAL_TIMEOUT_CYC
)
(
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire loop_mode_pkg::mode_cfg_t    mode_cfg,
    input wire loop_mode_pkg::ref_cfg_t     ref_cfg,
    input wire loop_mode_pkg::fbdiv_cfg_t   fbdiv_cfg,
    input wire logic                        apll_lock_raw,
    input wire logic                        lock_loss_clear,
    input wire logic                        bias_rst_n,
    input wire logic                        bias_cal_start,
    input wire logic                        apll_rst_n,
    input wire logic                        dpll_rst_n,
    input wire logic                        out_rst_n,
    input wire logic                        bias_cal_done,
    input wire logic                        bias_cal_fail,
    input wire logic                        ja_mode,
    input wire loop_mode_pkg::ref_cfg_t     ref_out,
    input wire loop_mode_pkg::lpf_cfg_t     lpf_out,
    input wire logic                        apll_lock_sts,
    input wire logic                        lock_loss
);
    localparam int WAIT_MAX = CAL_TIMEOUT + 3;
    logic [31:0] wait_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence bias_up;
        $rose(bias_rst_n);
    endsequence
    sequence cal_pulse;
        bias_cal_start ##1 !bias_cal_start;
    endsequence

    // A silent calibration would otherwise stall startup for good.
    always_ff @(posedge clk)
        wait_ff <= (!rst_n || !bias_rst_n || bias_cal_done || bias_cal_fail) ? 32'h0 :
                   (bias_cal_start || wait_ff != 32'h0) ? wait_ff + 32'h1 : 32'h0;

    cal_launch_a: assert property (bias_up |-> ##24 cal_pulse)
        else $error("late calibration start");
    cal_bound_a: assert property (wait_ff <= WAIT_MAX)
        else $error("calibration overran");
    fail_sticky_a: assert property (bias_cal_fail |=> bias_cal_fail)
        else $error("fail flag dropped");
    apll_after_cal_a: assert property ($rose(apll_rst_n) |-> bias_cal_done || bias_cal_fail)
        else $error("early loop release");
    dpll_stage_a: assert property ($rose(dpll_rst_n) |-> $past(apll_rst_n, 25) && !$past(apll_rst_n, 26))
        else $error("digital loop release mistimed");
    out_stage_a: assert property ($rose(out_rst_n) |-> $past(dpll_rst_n, 25) && !$past(dpll_rst_n, 26))
        else $error("output release mistimed");
    ja_follow_a: assert property ($past(rst_n) |-> ja_mode == ($past(mode_cfg.dpll_en) & $past(ref_cfg.inbuff_en)))
        else $error("mode decode wrong");
    pad_gate_a: assert property ($past(rst_n) |-> ref_out.inbuff_en == ($past(ref_cfg.inbuff_en) & $past(mode_cfg.dpll_en)))
        else $error("input pad enable wrong");
    bypass_gate_a: assert property (lpf_out.third_pole_bypass |-> $past(fbdiv_cfg.feedback_fraction_numerator) == FRAC_ZERO)
        else $error("bypass with fraction");
    loss_set_a: assert property ($fell(apll_lock_sts) |-> ##[0:1] lock_loss)
        else $error("lock loss not set");
    loss_hold_a: assert property (lock_loss && !lock_loss_clear |=> lock_loss)
        else $error("lock loss dropped");
    loss_clear_a: assert property (lock_loss_clear && apll_lock_raw && apll_rst_n |=> !lock_loss)
        else $error("lock loss not cleared");
endmodule // loop_mode_chk

bind analog_loop_mode_control loop_mode_chk #(.CAL_TIMEOUT(CAL_TIMEOUT)) loop_mode_chk_inst (.*);

// ### dv/test_analog_loop_mode_control.sv
// Self-checking bench for the analog loop mode control block.
`timescale 1ns/1ps
module test_analog_loop_mode_control;
    import loop_mode_pkg::*;
    localparam int CAL_T = 50;
    logic        clk, rst_n, regulators_ok, bias_cal_finished, bias_cal_error, doubler_en, doubler_src_ref;
    logic        apll_lock_raw, lock_loss_clear, gpio_lock_sel, fb_tick, ja_req, cmos_req, ac_req, byp_req;
    logic        byp_force, byp, bias_rst_n, bias_cal_start, apll_rst_n, dpll_rst_n, out_rst_n, bias_cal_done;
    logic        bias_cal_fail, ja_mode, dpll_power_on, doubler_en_out, doubler_src_out, apll_lock_sts;
    logic        lock_loss, gpio_lock;
    logic [1:0]  ref_band, lock_range, lock_range_out;
    logic [15:0] lpf_r;
    logic [31:0] rnd;
    logic [8:0]  div_ratio;
    logic signed [31:0] osc_offset_word, dpll_steer_word;
    logic signed [15:0] xtal_trim_word;
    logic signed [32:0] off;
    mode_cfg_t   mode_cfg;
    ref_cfg_t    ref_cfg, ref_out;
    xtal_cfg_t   xtal_cfg, xtal_out;
    lpf_cfg_t    lpf_cfg, lpf_out;
    fbdiv_cfg_t  fbdiv_cfg, fb_ratio_out;
    int          num_errors, num_checks, n, k, sum;

    assign lpf_cfg = {lpf_r, byp};

    host_model host_model_inst (.ja_req, .cmos_req, .ac_req, .byp_req, .byp_force, .ref_band,
        .frac(fbdiv_cfg.feedback_fraction_numerator), .mode_cfg, .ref_cfg, .bypass(byp), .lock_range);

    analog_loop_mode_control #(.CAL_TIMEOUT(CAL_T)) analog_loop_mode_control_inst (.clk, .rst_n, .regulators_ok,
        .bias_cal_finished, .bias_cal_error, .mode_cfg, .xtal_cfg, .ref_cfg, .lpf_cfg, .fbdiv_cfg, .doubler_en,
        .doubler_src_ref, .lock_range, .osc_offset_word, .xtal_trim_word, .dpll_steer_word, .apll_lock_raw,
        .lock_loss_clear, .gpio_lock_sel, .fb_tick, .bias_rst_n, .bias_cal_start, .apll_rst_n, .dpll_rst_n,
        .out_rst_n, .bias_cal_done, .bias_cal_fail, .ja_mode, .dpll_power_on, .xtal_out, .ref_out, .lpf_out,
        .doubler_en_out, .doubler_src_out, .lock_range_out, .fb_ratio_out, .div_ratio, .apll_lock_sts,
        .lock_loss, .gpio_lock);

    task automatic tick(input int cycles);
        repeat (cycles) @(posedge clk);
        #2;
    endtask

    task automatic fb_pulse;
        fb_tick = 1'b1;
        tick(1);
        fb_tick = 1'b0;
        tick(1);
    endtask

    task automatic check(input string what, input logic [69:0] seen, input logic [69:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Signed offset scaled by the ratio, 40 fraction bits, rounded toward minus infinity.
    function automatic logic [34:0] exp_ratio(input logic [34:0] r, input logic signed [32:0] o);
        logic signed [69:0] p;
        p = $signed({35'h0, r}) * o;
        return r + 35'(p >>> 40);
    endfunction

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        {rst_n, regulators_ok, bias_cal_finished, bias_cal_error, doubler_en, doubler_src_ref} = 6'h00;
        {apll_lock_raw, lock_loss_clear, gpio_lock_sel, fb_tick, ja_req, cmos_req, ac_req, byp_req} = 8'h00;
        {byp_force, ref_band, lpf_r, xtal_cfg, fbdiv_cfg} = 66'h0;
        {osc_offset_word, dpll_steer_word, xtal_trim_word} = 80'h0;
        num_errors = 0;
        num_checks = 0;
        void'($urandom(1204));
        tick(10);
        rst_n = 1'b1;
        tick(1);
        check("ja_mode", ja_mode, 0);
        check("pad", ref_out.inbuff_en, 0);
        regulators_ok = 1'b1;
        repeat (200) if (apll_rst_n !== 1'b1) tick(1);
        check("cal_timeout", {bias_cal_done, bias_cal_fail, apll_rst_n}, 3'h3);
        tick(60);
        check("out_release", out_rst_n, 1);
        regulators_ok = 1'b0;
        tick(3);
        check("hold", {apll_rst_n, bias_cal_fail}, 2'h1);
        rst_n = 1'b0;
        tick(10);
        rst_n = 1'b1;
        tick(1);
        regulators_ok = 1'b1;
        tick(5);
        bias_cal_finished = 1'b1;
        tick(1);
        bias_cal_finished = 1'b0;
        repeat (60) if (bias_cal_start !== 1'b1) tick(1);
        check("early_finish", {bias_cal_done, bias_cal_fail}, 2'h0);
        bias_cal_finished = 1'b1;
        tick(1);
        bias_cal_finished = 1'b0;
        repeat (60) if (apll_rst_n !== 1'b1) tick(1);
        check("cal_done", {bias_cal_done, bias_cal_fail}, 2'h2);
        for (n = 0; n < 100 && dpll_rst_n !== 1'b1; n++) tick(1);
        check("stage", n, STAGE_CYC);
        for (k = 0; k < 24; k++)
        begin
            rnd = $urandom;
            {doubler_en, doubler_src_ref, ja_req, cmos_req, ac_req, byp_req, byp_force, ref_band} = rnd[8:0];
            xtal_cfg = rnd[31:20];
            rnd = $urandom;
            lpf_r = rnd[15:0];
            fbdiv_cfg = {rnd[31:24] | 8'h10, (k % 3 == 0) ? 27'h0000000 : 27'($urandom)};
            rnd = $urandom;
            osc_offset_word = (k == 1) ? 32'h80000000 : $signed(rnd) >>> 1;
            dpll_steer_word = $signed(~rnd) >>> 2;
            xtal_trim_word = (k == 1) ? 16'h0000 : rnd[15:0];
            tick(3);
            off = ja_req ? dpll_steer_word : osc_offset_word + xtal_trim_word;
            check("ratio", fb_ratio_out, exp_ratio(fbdiv_cfg, off));
            check("xtal", xtal_out, xtal_cfg);
            check("doubler", {doubler_en_out, doubler_src_out}, {doubler_en, doubler_src_ref});
            check("range", lock_range_out, ref_band);
            check("ref", ref_out, {cmos_req, ac_req & ~cmos_req, ac_req & cmos_req, ja_req});
            check("mode", {ja_mode, dpll_power_on}, {2{ja_req}});
            check("lpf", lpf_out, {lpf_r, byp_req && fbdiv_cfg.feedback_fraction_numerator == 27'h0});
        end
        ja_req = 1'b0;
        {osc_offset_word, xtal_trim_word} = 48'h0;
        fbdiv_cfg = {8'h40, 27'h0000000};
        tick(3);
        fb_pulse();
        check("div_int", div_ratio, 9'h040);
        fbdiv_cfg = {8'h40, 27'h2000000};
        tick(3);
        sum = 0;
        repeat (64)
        begin
            fb_pulse();
            sum += div_ratio;
        end
        check("div_mean", sum inside {[4111:4113]}, 1);
        {gpio_lock_sel, apll_lock_raw} = 2'h3;
        tick(3);
        check("lock", {apll_lock_sts, gpio_lock, lock_loss}, 3'h6);
        {gpio_lock_sel, apll_lock_raw} = 2'h0;
        tick(3);
        check("loss", {apll_lock_sts, gpio_lock, lock_loss}, 3'h1);
        apll_lock_raw = 1'b1;
        tick(3);
        check("sticky", {apll_lock_sts, gpio_lock, lock_loss}, 3'h5);
        lock_loss_clear = 1'b1;
        tick(1);
        lock_loss_clear = 1'b0;
        tick(2);
        check("clear", lock_loss, 0);
        apll_lock_raw = 1'b0;
        lock_loss_clear = 1'b1;
        tick(1);
        lock_loss_clear = 1'b0;
        tick(3);
        check("race", lock_loss, 1);
        rst_n = 1'b0;
        tick(1);
        rst_n = 1'b1;
        tick(26);
        {bias_cal_finished, bias_cal_error} = 2'h3;
        tick(1);
        check("cal_err", {bias_cal_done, bias_cal_fail}, 2'h1);
        end_of_test();
    end
endmodule // test_analog_loop_mode_control
